// ---- hdl/i2cscr_pkg.sv ----
// constants and types for the two-wire status, clock and reset block
package i2cscr_pkg;

  // register port
  localparam int IO_ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] CLKDIV_ADDR = 16'h00cc;
  localparam logic [15:0] SOFTRST_ADDR = 16'h00cd;

  // divider field layout and reset value
  localparam int DIV_EXP_LSB = 0;
  localparam int DIV_EXP_W = 3;
  localparam int DIV_SCL_LSB = 3;
  localparam int DIV_SCL_W = 4;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // half an SCL period is five sample periods times (scalar+1)
  localparam int SCL_HALF_MULT = 5;

  // pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // status codes
  localparam logic [7:0] ST_BUS_ERROR = 8'h00;
  localparam logic [7:0] ST_START_TX = 8'h08;
  localparam logic [7:0] ST_ARB_SLV_RD = 8'hb0;
  localparam logic [7:0] ST_STX_ACK = 8'hb8;
  localparam logic [7:0] ST_STX_NACK = 8'hc0;
  localparam logic [7:0] ST_STX_LAST = 8'hc8;
  localparam logic [7:0] ST_A2W_ACK = 8'hd0;
  localparam logic [7:0] ST_A2W_NACK = 8'hd8;
  localparam logic [7:0] ST_IDLE = 8'hf8;
  localparam logic [7:0] STATUS_RESET = ST_IDLE;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // byte-level events reported by the transfer engine
  typedef enum logic [2:0] {
    EVT_ARB_SLV_RD,
    EVT_STX_ACK,
    EVT_STX_NACK,
    EVT_STX_LAST_ACK,
    EVT_A2W_ACK,
    EVT_A2W_NACK
  } i2cscr_evt_t;

  // recovery and start sequencing states
  typedef enum logic [1:0] {
    CS_IDLE,
    CS_ERROR,
    CS_START_SETUP,
    CS_START_HOLD
  } i2cscr_state_t;

endpackage : i2cscr_pkg

// ---- hdl/i2cscr_clkdiv.sv ----
// sampling and SCL half-period tick generator
`timescale 1ns/1ps
`default_nettype none
module i2cscr_clkdiv #(
  parameter int EXP_W = 3,
  parameter int SCL_W = 4,
  parameter int HALF_MULT = 5
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic soft_rst_i,
  // divider settings
  input wire logic [EXP_W-1:0] exp_i,
  input wire logic [SCL_W-1:0] scalar_i,
  input wire logic scl_run_i,
  // ticks
  output logic samp_tick_o,
  output logic half_tick_o
);

  localparam int PRE_W = (1 << EXP_W);
  localparam int HALF_W = SCL_W + 4;

  // refuse widths the counters cannot hold
  if (EXP_W < 1 || EXP_W > 5 || SCL_W < 1 || HALF_MULT < 1
      || HALF_MULT > 16)
  begin : g_bad_params
    $error("i2cscr_clkdiv: unsupported divider widths");
  end

  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;
  logic [HALF_W-1:0] half_q;
  logic [HALF_W-1:0] half_d;
  wire [PRE_W-1:0] pre_last = PRE_W'((1 << exp_i) - 1);
  wire [HALF_W-1:0] half_last =
    HALF_W'(HALF_MULT * (int'(scalar_i) + 1) - 1);

  // prescaler ticks every 2^exp cycles
  assign samp_tick_o = (pre_q >= pre_last);
  assign pre_d = samp_tick_o ? '0 : pre_q + 1'b1;
  // half period counts 5*(scalar+1) sample ticks
  assign half_tick_o = scl_run_i && samp_tick_o && (half_q >= half_last);
  assign half_d = !scl_run_i ? '0 :
                  half_tick_o ? '0 :
                  samp_tick_o ? half_q + 1'b1 : half_q;

  // counter registers
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pre_q <= '0;
      half_q <= '0;
    end
    else if (soft_rst_i)
    begin
      pre_q <= '0;
      half_q <= '0;
    end
    else
    begin
      pre_q <= pre_d;
      half_q <= half_d;
    end
  end

endmodule : i2cscr_clkdiv
`default_nettype wire

// ---- hdl/i2cscr_top.sv ----
// two-wire controller status codes, bus error recovery, divider, soft reset
`timescale 1ns/1ps
`default_nettype none
module i2cscr_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // cpu i/o port
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // control bits
  input wire logic ctl_start_set_i,
  input wire logic ctl_stop_set_i,
  input wire logic ctl_flag_clear_i,
  output logic irq_pending_flag_o,
  output logic start_request_o,
  output logic stop_request_o,
  output logic bus_error_o,
  // transfer engine
  input wire logic evt_strobe_i,
  input wire i2cscr_pkg::i2cscr_evt_t evt_kind_i,
  input wire logic byte_active_i,
  input wire logic master_active_i,
  output logic stop_cmd_o,
  output logic samp_tick_o,
  // bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o
);

  // register state
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic flag_q;
  logic flag_d;
  logic start_q;
  logic start_d;
  logic stop_q;
  logic stop_d;
  logic soft_rst_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic stop_cmd_q;
  logic stop_cmd_d;
  i2cscr_pkg::i2cscr_state_t state_q;
  i2cscr_pkg::i2cscr_state_t state_d;

  // pin sampling state
  logic [i2cscr_pkg::SYNC_STAGES-1:0] scl_sync_q;
  logic [i2cscr_pkg::SYNC_STAGES-1:0] sda_sync_q;
  logic scl_f_q;
  logic sda_f_q;
  logic sda_prev_q;
  logic scl_phase_q;
  logic scl_phase_d;
  logic scl_oe_n_q;
  logic sda_low_q;
  logic sda_low_d;

  // divider ticks
  logic samp_tick;
  logic half_tick;

  // address decode
  wire div_sel = (io_addr_i == i2cscr_pkg::CLKDIV_ADDR);
  wire srst_sel = (io_addr_i == i2cscr_pkg::SOFTRST_ADDR);
  wire div_wr = io_wr_i && div_sel;
  wire status_rd = io_rd_i && div_sel;
  wire srst_wr = io_wr_i && srst_sel;

  // divider fields, bit 7 reserved
  wire [2:0] div_exp =
    div_q[i2cscr_pkg::DIV_EXP_LSB +: i2cscr_pkg::DIV_EXP_W];
  wire [3:0] div_scalar =
    div_q[i2cscr_pkg::DIV_SCL_LSB +: i2cscr_pkg::DIV_SCL_W];

  // start/stop detection on filtered, sampled lines
  wire sda_fall = sda_prev_q && !sda_f_q;
  wire sda_rise = !sda_prev_q && sda_f_q;
  wire cond_seen = scl_f_q && (sda_fall || sda_rise);
  wire bus_err_det = cond_seen && byte_active_i
                     && (state_q == i2cscr_pkg::CS_IDLE);

  // sequencing events
  wire in_error = (state_q == i2cscr_pkg::CS_ERROR);
  wire err_exit = in_error && !flag_q && stop_q;
  wire start_done = (state_q == i2cscr_pkg::CS_START_HOLD) && half_tick;
  wire scl_run = (master_active_i && !flag_q)
                 || (state_q == i2cscr_pkg::CS_START_SETUP)
                 || (state_q == i2cscr_pkg::CS_START_HOLD);

  // status code for an engine event
  logic [7:0] evt_code;
  always_comb
  begin
    evt_code = i2cscr_pkg::ST_IDLE;
    unique case (evt_kind_i)
      i2cscr_pkg::EVT_ARB_SLV_RD: evt_code = i2cscr_pkg::ST_ARB_SLV_RD;
      i2cscr_pkg::EVT_STX_ACK: evt_code = i2cscr_pkg::ST_STX_ACK;
      i2cscr_pkg::EVT_STX_NACK: evt_code = i2cscr_pkg::ST_STX_NACK;
      i2cscr_pkg::EVT_STX_LAST_ACK: evt_code = i2cscr_pkg::ST_STX_LAST;
      i2cscr_pkg::EVT_A2W_ACK: evt_code = i2cscr_pkg::ST_A2W_ACK;
      i2cscr_pkg::EVT_A2W_NACK: evt_code = i2cscr_pkg::ST_A2W_NACK;
      default: evt_code = i2cscr_pkg::ST_IDLE;
    endcase
  end

  // which defined state is entered this cycle, errors first
  wire state_enter = bus_err_det || start_done
                     || (evt_strobe_i && !in_error);
  wire [7:0] enter_code = bus_err_det ? i2cscr_pkg::ST_BUS_ERROR :
                          start_done ? i2cscr_pkg::ST_START_TX :
                          evt_code;

  // flag and status: entering a state wins over a clear
  assign flag_d = state_enter ? 1'b1 :
                  ctl_flag_clear_i ? 1'b0 : flag_q;
  assign status_d = state_enter ? enter_code :
                    ctl_flag_clear_i ? i2cscr_pkg::ST_IDLE :
                    status_q;

  // divider register and read data
  assign div_d = div_wr ? io_wdata_i : div_q;
  assign rdata_d = status_rd ? status_q : i2cscr_pkg::RDATA_NONE;

  // request bits: set by software, cleared by hardware when acted on
  wire stop_taken = err_exit || (stop_q && !in_error);
  assign stop_d = ctl_stop_set_i ? 1'b1 :
                  stop_taken ? 1'b0 : stop_q;
  assign start_d = ctl_start_set_i ? 1'b1 :
                   start_done ? 1'b0 : start_q;
  // stop outside bus error goes to the engine; none driven on recovery
  assign stop_cmd_d = stop_q && !in_error;

  // recovery and start sequence
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      i2cscr_pkg::CS_IDLE:
        if (bus_err_det)
          state_d = i2cscr_pkg::CS_ERROR;
      i2cscr_pkg::CS_ERROR:
        if (err_exit)
          state_d = start_q ? i2cscr_pkg::CS_START_SETUP
                            : i2cscr_pkg::CS_IDLE;
      i2cscr_pkg::CS_START_SETUP:
        if (half_tick)
          state_d = i2cscr_pkg::CS_START_HOLD;
      i2cscr_pkg::CS_START_HOLD:
        if (half_tick)
          state_d = i2cscr_pkg::CS_IDLE;
    endcase
  end

  // sda held low from the generated START until the flag is cleared
  assign sda_low_d = (state_q == i2cscr_pkg::CS_START_HOLD) ? 1'b1 :
                     ctl_flag_clear_i ? 1'b0 : sda_low_q;
  // master clock phase; set in the low half while running
  assign scl_phase_d = !scl_run ? 1'b0 :
                       half_tick ? !scl_phase_q : scl_phase_q;

  // divider tick generator
  i2cscr_clkdiv #(
    .EXP_W(i2cscr_pkg::DIV_EXP_W),
    .SCL_W(i2cscr_pkg::DIV_SCL_W),
    .HALF_MULT(i2cscr_pkg::SCL_HALF_MULT)
  ) u_clkdiv (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .soft_rst_i(soft_rst_q),
    .exp_i(div_exp),
    .scalar_i(div_scalar),
    .scl_run_i(scl_run),
    .samp_tick_o(samp_tick),
    .half_tick_o(half_tick)
  );

  // soft reset is registered then clears every register except the pin synchronisers
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= srst_wr;
  end

  // pin synchronisers, three stages each
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      scl_sync_q <= '1;
      sda_sync_q <= '1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
    end
  end

  // filtered levels update on sample ticks when stages 2 and 3 agree
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else if (soft_rst_q)
    begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else if (samp_tick)
    begin
      if (scl_sync_q[1] == scl_sync_q[2])
        scl_f_q <= scl_sync_q[2];
      if (sda_sync_q[1] == sda_sync_q[2])
        sda_f_q <= sda_sync_q[2];
      sda_prev_q <= sda_f_q;
    end
  end

  // control and status registers
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      div_q <= i2cscr_pkg::DIV_RESET;
      status_q <= i2cscr_pkg::STATUS_RESET;
      flag_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      stop_cmd_q <= 1'b0;
      state_q <= i2cscr_pkg::CS_IDLE;
    end
    else if (soft_rst_q)
    begin
      div_q <= i2cscr_pkg::DIV_RESET;
      status_q <= i2cscr_pkg::STATUS_RESET;
      flag_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      stop_cmd_q <= 1'b0;
      state_q <= i2cscr_pkg::CS_IDLE;
    end
    else
    begin
      div_q <= div_d;
      status_q <= status_d;
      flag_q <= flag_d;
      start_q <= start_d;
      stop_q <= stop_d;
      stop_cmd_q <= stop_cmd_d;
      state_q <= state_d;
    end
  end

  // read data and pin drive registers
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rdata_q <= i2cscr_pkg::RDATA_NONE;
      scl_phase_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_low_q <= 1'b0;
    end
    else if (soft_rst_q)
    begin
      rdata_q <= i2cscr_pkg::RDATA_NONE;
      scl_phase_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_low_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      scl_phase_q <= scl_phase_d;
      // pull scl low while the flag stands or in the master low half
      scl_oe_n_q <= !(flag_d || (master_active_i && scl_phase_d));
      sda_low_q <= sda_low_d;
    end
  end

  // outputs
  assign io_rdata_o = rdata_q;
  assign irq_pending_flag_o = flag_q;
  assign start_request_o = start_q;
  assign stop_request_o = stop_q;
  assign bus_error_o = in_error;
  assign stop_cmd_o = stop_cmd_q;
  assign samp_tick_o = samp_tick;
  assign scl_o = 1'b0;
  assign scl_oe_n_o = scl_oe_n_q;
  assign sda_o = 1'b0;
  assign sda_oe_n_o = !sda_low_q;

endmodule : i2cscr_top
`default_nettype wire

// ---- dv/i2cscr_checker.sv ----
// assertion checker for the status, clock and reset block
`timescale 1ns/1ps
`default_nettype none
module i2cscr_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // cpu port and control bits
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic ctl_stop_set_i,
  input wire logic ctl_flag_clear_i,
  input wire logic evt_strobe_i,
  // status outputs and pins
  input wire logic irq_pending_flag_o,
  input wire logic stop_request_o,
  input wire logic bus_error_o,
  input wire logic stop_cmd_o,
  input wire logic scl_oe_n_o,
  input wire logic sda_oe_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // status and read port
  status_idle_a: assert property (
    io_rd_i && io_addr_i == 16'h00cc && !irq_pending_flag_o
    |=> io_rdata_o == 8'hf8) else $error("idle status not f8");
  unmapped_read_a: assert property (
    io_rd_i && io_addr_i != 16'h00cc |=> io_rdata_o == 8'h00)
    else $error("other address read not zero");
  // flag set and clear
  evt_flag_a: assert property (
    evt_strobe_i && !bus_error_o |=> irq_pending_flag_o)
    else $error("event did not set flag");
  flag_clear_a: assert property (
    ctl_flag_clear_i && !evt_strobe_i |=> !irq_pending_flag_o)
    else $error("flag clear ignored");
  scl_hold_a: assert property (
    irq_pending_flag_o |-> !scl_oe_n_o) else $error("scl not held low");
  // stop request outside bus error
  stop_pulse_a: assert property (
    ctl_stop_set_i && !bus_error_o |=> stop_request_o
    ##1 (stop_cmd_o && !stop_request_o) ##1 !stop_cmd_o)
    else $error("stop request misbehaved");
  // bus error behaviour
  err_quiet_a: assert property (
    bus_error_o |-> sda_oe_n_o && !stop_cmd_o)
    else $error("bus driven in bus error");
  err_exit_a: assert property (
    bus_error_o && !stop_request_o |=> bus_error_o)
    else $error("bus error left without stop");
  err_flag_a: assert property (
    $rose(bus_error_o) |-> ##[0:1] irq_pending_flag_o)
    else $error("bus error without flag");
endmodule : i2cscr_checker
`default_nettype wire

// ---- dv/i2cscr_bus_model.sv ----
// two-wire bus with pull-ups and another party that can upset it
`timescale 1ns/1ps
`default_nettype none
module i2cscr_bus_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // device pin enables and upset request
  input wire logic scl_oe_n_i,
  input wire logic sda_oe_n_i,
  input wire logic upset_i,
  // resolved lines and condition counts
  output logic scl_o,
  output logic sda_o,
  output int start_cnt_o,
  output int stop_cnt_o
);
  int n;
  logic sda_q;
  // pull-ups: a line is low only while someone pulls it
  assign scl_o = scl_oe_n_i;
  assign sda_o = sda_oe_n_i & !(n > 4 && n < 20);
  // upset: data falls then rises with the clock line high
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      n <= 0;
      sda_q <= 1'b1;
      start_cnt_o <= 0;
      stop_cnt_o <= 0;
    end
    else
    begin
      n <= upset_i ? 24 : (n > 0 ? n - 1 : 0);
      sda_q <= sda_o;
      if (scl_o && sda_q && !sda_o) start_cnt_o <= start_cnt_o + 1;
      if (scl_o && !sda_q && sda_o) stop_cnt_o <= stop_cnt_o + 1;
    end
  end
endmodule : i2cscr_bus_model
`default_nettype wire

// ---- dv/i2cscr_top_tb.sv ----
// self-checking bench for the status, clock and reset block
`timescale 1ns/1ps
`default_nettype none
module i2cscr_top_tb;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic [7:0] io_wdata_i = 8'h00, io_rdata_o;
  logic ctl_start_set_i = 1'b0, ctl_stop_set_i = 1'b0;
  logic ctl_flag_clear_i = 1'b0, evt_strobe_i = 1'b0, upset = 1'b0;
  logic byte_active_i = 1'b0, master_active_i = 1'b0;
  i2cscr_pkg::i2cscr_evt_t evt_kind_i = i2cscr_pkg::EVT_STX_ACK;
  logic irq_pending_flag_o, start_request_o, stop_request_o, bus_error_o;
  logic stop_cmd_o, samp_tick_o, scl, sda, scl_oe_n_o, sda_oe_n_o;
  logic scl_out, sda_out;
  int error_cnt = 0, n_compared = 0, k, s0, p0;
  logic [7:0] codes [6] = '{8'hb0, 8'hb8, 8'hc0, 8'hc8, 8'hd0, 8'hd8};
  // device and the bus it sits on
  i2cscr_top i_i2cscr_top (.ref_clk_i, .reset_i, .io_addr_i, .io_wr_i,
    .io_rd_i, .io_wdata_i, .io_rdata_o, .ctl_start_set_i, .ctl_stop_set_i,
    .ctl_flag_clear_i, .irq_pending_flag_o, .start_request_o,
    .stop_request_o, .bus_error_o, .evt_strobe_i, .evt_kind_i,
    .byte_active_i, .master_active_i, .stop_cmd_o, .samp_tick_o,
    .scl_i(scl), .scl_o(scl_out), .scl_oe_n_o, .sda_i(sda),
    .sda_o(sda_out), .sda_oe_n_o);
  i2cscr_bus_model i_i2cscr_bus_model (.clk_i(ref_clk_i), .rst_i(reset_i),
    .scl_oe_n_i(scl_oe_n_o), .sda_oe_n_i(sda_oe_n_o), .upset_i(upset),
    .scl_o(scl), .sda_o(sda), .start_cnt_o(s0), .stop_cnt_o(p0));
  // 40 MHz clock
  initial
  begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) error_cnt++;
    if (s !== e) $display("[ERR] %s exp %h got %h", n, e, s);
  endtask : chk
  task automatic tmo(input string n, input logic s);
    chk(n, 8'h01, {7'h00, s});
    if (s !== 1'b1) complete_run();
  endtask : tmo
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    {io_wr_i, io_rd_i, io_addr_i, io_wdata_i} = {w, !w, a, d};
    @(negedge ref_clk_i);
    {io_wr_i, io_rd_i} = 2'b00;
  endtask : io
  task automatic rd_chk(input string n, input logic [15:0] a, input logic [7:0] e);
    io(1'b0, a, 8'h00);
    chk(n, e, io_rdata_o);
  endtask : rd_chk
  task automatic pulse(ref logic s);
    @(negedge ref_clk_i);
    s = 1'b1;
    @(negedge ref_clk_i);
    s = 1'b0;
  endtask : pulse
  task automatic ticks(input int c, input int e);
    k = 0;
    repeat (c)
    begin
      @(negedge ref_clk_i);
      k += samp_tick_o;
    end
    chk("samp ticks", e[7:0], k[7:0]);
  endtask : ticks
  // every engine event loads its code, sets flag, holds scl
  task automatic t_codes;
    for (int i = 0; i < 6; i++)
    begin
      evt_kind_i = i2cscr_pkg::i2cscr_evt_t'(i);
      pulse(evt_strobe_i);
      chk("scl oe_n", 8'h00, {7'h00, scl_oe_n_o});
      rd_chk("status", 16'h00cc, codes[i]);
      pulse(ctl_flag_clear_i);
      rd_chk("status", 16'h00cc, 8'hf8);
      chk("scl oe_n", 8'h01, {7'h00, scl_oe_n_o});
    end
  endtask : t_codes
  // sampling rate and master scl period from the divider
  task automatic t_div;
    io(1'b1, 16'h00cc, 8'h02);
    ticks(64, 16);
    io(1'b1, 16'h00cc, 8'h09);
    master_active_i = 1'b1;
    for (k = 0; k < 200 && scl_oe_n_o !== 1'b0; k++) @(negedge ref_clk_i);
    for (k = 0; k < 200 && scl_oe_n_o !== 1'b1; k++) @(negedge ref_clk_i);
    for (k = 0; k < 200 && scl_oe_n_o !== 1'b0; k++) @(negedge ref_clk_i);
    for (; k < 200 && scl_oe_n_o !== 1'b1; k++) @(negedge ref_clk_i);
    tmo("scl toggle", k < 200);
    chk("scl period", 8'd40, k[7:0]);
    master_active_i = 1'b0;
    io(1'b1, 16'h00cc, 8'h00);
    ticks(8, 8);
  endtask : t_div
  // upset the bus mid-byte and wait for the error state
  task automatic t_err;
    byte_active_i = 1'b1;
    pulse(upset);
    for (k = 0; k < 100 && bus_error_o !== 1'b1; k++) @(negedge ref_clk_i);
    tmo("bus error", bus_error_o);
    repeat (30) @(negedge ref_clk_i);
    byte_active_i = 1'b0;
    rd_chk("error status", 16'h00cc, 8'h00);
  endtask : t_err
  // leave bus error quietly, then again with a start
  task automatic t_recover;
    int st, sp;
    t_err();
    {st, sp} = {s0, p0};
    pulse(ctl_stop_set_i);
    repeat (3) @(negedge ref_clk_i);
    chk("stay error", 8'h01, {7'h00, bus_error_o});
    pulse(ctl_flag_clear_i);
    repeat (3) @(negedge ref_clk_i);
    chk("left error", 8'h00, {7'h00, bus_error_o});
    chk("stop count", sp[7:0], p0[7:0]);
    chk("stop req", 8'h00, {7'h00, stop_request_o});
    rd_chk("status", 16'h00cc, 8'hf8);
    t_err();
    st = s0;
    @(negedge ref_clk_i);
    {ctl_stop_set_i, ctl_start_set_i} = 2'b11;
    @(negedge ref_clk_i);
    {ctl_stop_set_i, ctl_start_set_i} = 2'b00;
    chk("start req", 8'h01, {7'h00, start_request_o});
    pulse(ctl_flag_clear_i);
    for (k = 0; k < 200 && irq_pending_flag_o !== 1'b1; k++)
      @(negedge ref_clk_i);
    tmo("start flag", irq_pending_flag_o);
    chk("start count", st[7:0] + 8'h01, s0[7:0]);
    rd_chk("start status", 16'h00cc, 8'h08);
    chk("start req", 8'h00, {7'h00, start_request_o});
    chk("sda held", 8'h00, {7'h00, sda_oe_n_o});
    pulse(ctl_flag_clear_i);
    chk("sda freed", 8'h01, {7'h00, sda_oe_n_o});
  endtask : t_recover
  // stop outside error, unmapped reads, soft reset
  task automatic t_misc;
    pulse(ctl_stop_set_i);
    chk("stop req", 8'h01, {7'h00, stop_request_o});
    @(negedge ref_clk_i);
    chk("stop cmd", 8'h01, {7'h00, stop_cmd_o});
    chk("stop req", 8'h00, {7'h00, stop_request_o});
    @(negedge ref_clk_i);
    chk("stop cmd", 8'h00, {7'h00, stop_cmd_o});
    rd_chk("unmapped", 16'h00cd, 8'h00);
    rd_chk("unmapped", 16'h01cc, 8'h00);
    io(1'b1, 16'h00cc, 8'h7a);
    pulse(evt_strobe_i);
    io(1'b1, 16'h00cd, 8'h5a);
    @(negedge ref_clk_i);
    chk("flag", 8'h00, {7'h00, irq_pending_flag_o});
    rd_chk("status", 16'h00cc, 8'hf8);
    ticks(8, 8);
  endtask : t_misc
  task automatic complete_run;
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // main sequence
  initial
  begin
    repeat (4) @(negedge ref_clk_i);
    reset_i = 1'b0;
    chk("flag", 8'h00, {7'h00, irq_pending_flag_o});
    chk("sda oe_n", 8'h01, {7'h00, sda_oe_n_o});
    chk("scl out", 8'h00, {7'h00, scl_out});
    chk("sda out", 8'h00, {7'h00, sda_out});
    rd_chk("status", 16'h00cc, 8'hf8);
    t_codes();
    t_div();
    t_recover();
    t_misc();
    complete_run();
  end
endmodule : i2cscr_top_tb
bind i2cscr_top i2cscr_checker i_i2cscr_checker (.ref_clk_i, .reset_i,
  .io_addr_i, .io_rd_i, .io_rdata_o, .ctl_stop_set_i, .ctl_flag_clear_i,
  .evt_strobe_i, .irq_pending_flag_o, .stop_request_o, .bus_error_o,
  .stop_cmd_o, .scl_oe_n_o, .sda_oe_n_o);
`default_nettype wire
